// [bench/driver_spi_datagram_port_tb_top.sv]
// Self-checking bench of the datagram port.
// Assumes the driver model in dsp_slave and a short poll block.
`timescale 1ns/100ps
module driver_spi_datagram_port_tb_top;
    import dsp_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [8:0] awaddr = 9'h0, araddr = 9'h0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cur_ready, miso, irq, stp, dirp;
    logic [1:0] bresp, rresp;
    dsp_dgram_t cur_dgram = 40'h0;
    logic cur_valid = 1'b0, step_req = 1'b0, dir_req = 1'b0;
    dsp_pins_t spi_pins;
    logic [39:0] got;
    int failures = 0, checks_done = 0, cyc = 0, t0, t1;
    // ==========================================================
    // Clock, design and driver model
    // ==========================================================
    always #50 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    dsp_port #(.POLL_BLOCK_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cur_dgram(cur_dgram), .cur_valid(cur_valid), .cur_ready(cur_ready),
        .step_req(step_req), .dir_req(dir_req), .spi_pins(spi_pins), .spi_miso(miso),
        .step_output_pin(stp), .direction_output_pin(dirp), .irq(irq));
    dsp_slave slave (.pins(spi_pins), .miso(miso), .got(got));
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
        checks_done++;
        if (s !== e)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic lim(input int n);
        if (n >= 2000)
        begin
            failures++;
            test_done();
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end
        while (bvalid !== 1'b1 && n < 2000);
        bready <= 1'b0;
        lim(n);
    endtask
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end
        while (rvalid !== 1'b1 && n < 2000);
        rready <= 1'b0;
        lim(n);
        chk("rdata", 40'(rdata), 40'(e));
    endtask
    // Waits for one whole frame and notes the cycle its select fell.
    task automatic frame(output int t);
        int n;
        n = 0;
        while (spi_pins.cs_n !== 1'b0 && n < 2000)
        begin
            @(posedge aclk);
            n++;
        end
        t = cyc;
        while (spi_pins.cs_n !== 1'b1 && n < 2000)
        begin
            @(posedge aclk);
            n++;
        end
        repeat (3) @(posedge aclk);
        lim(n);
    endtask
    task automatic cur(input logic [39:0] d);
        int n;
        cur_dgram <= d;
        cur_valid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (cur_ready !== 1'b1 && n < 2000);
        cur_valid <= 1'b0;
        lim(n);
        frame(t0);
        chk("current", got, d);
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_cover();
        rd(9'h010, 32'h0);
        rd(9'h1fc, 32'h0);
        chk("rresp", 40'(rresp), 40'(RESP_SLVERR));
        wr(9'h1fc, 32'h0);
        chk("bresp", 40'(bresp), 40'(RESP_SLVERR));
        wr(9'h010, 32'h0000_000d);
        chk("bresp", 40'(bresp), 40'(RESP_OKAY));
        wr(9'h1b4, 32'h0000_0022);
        wr(9'h1b0, 32'hdead_beef);
        frame(t0);
        chk("cover", got, 40'h22_dead_beef);
        chk("masked", 40'(irq), 40'h0);
        wr(9'h1cc, 32'h1);
        chk("irq", 40'(irq), 40'h1);
        rd(9'h1c0, 32'h0000_00a5);
        rd(9'h1c4, 32'h1234_5678);
        rd(9'h1c8, 32'h1);
        rd(9'h1c8, 32'h0);
        $display("cover test done");
    endtask
    task automatic t_current();
        cur(40'h41_0000_1234);
        rd(9'h1c8, 32'h1);
        wr(9'h010, 32'h0000_100d);
        cur(40'h42_8000_0001);
        rd(9'h1c8, 32'h0);
        $display("current test done");
    endtask
    task automatic t_poll();
        int n;
        wr(9'h040, 32'h0000_0302);
        wr(9'h010, 32'h0000_070c);
        cur_valid <= 1'b1;
        frame(t0);
        frame(t0);
        frame(t1);
        chk("period", 40'(t1 - t0), 40'(4 << 7));
        chk("poll", got, {POLL_ADDR, 32'h0});
        chk("no current", 40'(cur_ready), 40'h0);
        cur_valid <= 1'b0;
        rd(9'h1c8, 32'h3);
        dir_req <= 1'b1;
        step_req <= 1'b1;
        @(posedge aclk);
        step_req <= 1'b0;
        n = 0;
        repeat (20)
        begin
            @(posedge aclk);
            if (stp === 1'b1) n++;
        end
        chk("step", 40'(n), 40'd3);
        chk("dir", 40'(dirp), 40'h1);
        $display("poll and step test done");
    endtask
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_cover();
        t_current();
        t_poll();
        test_done();
    end
endmodule

// [bench/dsp_slave.sv]
// Driver chip model: a 40 bit mode 3 shift register with a fixed reply.
// Assumes sclk idles high and cs_n frames each datagram.
`timescale 1ns/100ps
module dsp_slave
(
    // Driver pins
    input dsp_pkg::dsp_pins_t pins,
    output logic miso,
    // Last datagram received
    output logic [39:0] got
);
    import dsp_pkg::*;
    logic [39:0] sh = 40'h0;
    int cnt = 0;
    initial miso = 1'b0;
    initial got = 40'h0;
    // Sample on the rising clock, msb first.
    always @(posedge pins.sclk)
    begin
        if (!pins.cs_n)
            sh = {sh[38:0], pins.mosi};
    end
    // Fixed reply word, sent msb first.
    localparam logic [39:0] REPLY = 40'ha5_1234_5678;
    logic cs_d = 1'b1;
    logic sclk_d = 1'b1;
    // Reply changes on falling clock; a select edge flips the line, so a released
    // line shows the inverse of its last value and a late sample would be caught.
    always @(pins.cs_n or pins.sclk)
    begin
        if (pins.cs_n !== cs_d)
        begin
            miso = ~miso;
            cnt = 0;
            if (pins.cs_n)
                got = sh;
        end
        else if (!pins.cs_n && sclk_d && !pins.sclk)
        begin
            miso = REPLY[39 - cnt];
            cnt++;
        end
        cs_d = pins.cs_n;
        sclk_d = pins.sclk;
    end
endmodule

// [verilog/dsp_pkg.sv]
// Shared constants and types of the driver datagram port.
// Assumes a single 10 MHz system clock and AXI4-Lite register access.
package dsp_pkg;
    // ==========================================================
    // Register map: word index, byte address is index times four
    // ==========================================================
    localparam int ADDR_W = 9;
    localparam logic [6:0] IDX_CONF = 7'h04;
    localparam logic [6:0] IDX_SDT = 7'h10;
    localparam logic [6:0] IDX_COV_LO = 7'h6c;
    localparam logic [6:0] IDX_COV_HI = 7'h6d;
    localparam logic [6:0] IDX_REP_HI = 7'h70;
    localparam logic [6:0] IDX_REP_LO = 7'h71;
    localparam logic [6:0] IDX_STAT = 7'h72;
    localparam logic [6:0] IDX_MASK = 7'h73;
    localparam logic [31:0] CONF_RST = 32'h0000_0000;
    localparam logic [31:0] SDT_RST = 32'h0000_0000;
    // ==========================================================
    // Output configuration fields
    // ==========================================================
    localparam int FMT_LSB = 0;
    localparam logic [3:0] FMT_SPI = 4'hd;
    localparam logic [3:0] FMT_SD = 4'hc;
    localparam int DISPOLL_BIT = 6;
    localparam int EXP_LSB = 8;
    localparam int CDONLY_BIT = 12;
    localparam int CLEN_LSB = 13;
    localparam int STPEXT_LSB = 0;
    localparam int DIRSET_LSB = 8;
    // ==========================================================
    // Interrupt status bits
    // ==========================================================
    localparam int ST_W = 2;
    localparam int ST_COVER_DONE = 0;
    localparam int ST_POLL_DONE = 1;
    // ==========================================================
    // Datagram and link timing
    // ==========================================================
    localparam int DG_W = 40;
    localparam logic [5:0] DG_BITS = 6'h28;
    localparam logic [7:0] POLL_ADDR = 8'h6f;
    localparam int CLK_NS = 100;
    localparam int LINK_NS = 800;
    localparam logic [7:0] HALF_CYC = 8'(LINK_NS / (2 * CLK_NS));
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } dsp_pins_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
    } dsp_dgram_t;
    typedef enum logic [3:0] {
        KIND_NONE = 4'b0001,
        KIND_COVER = 4'b0010,
        KIND_CURRENT = 4'b0100,
        KIND_POLL = 4'b1000
    } dsp_kind_t;
endpackage

// [verilog/dsp_port.sv]
// Top of the driver datagram port. Assumes an AXI4-Lite master on aclk and a
// current source on the same clock; miso arrives from outside the clock domain.
`timescale 1ns/100ps
module dsp_port
#(
    parameter int unsigned POLL_BLOCK_CYCLES = 64
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [dsp_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [dsp_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Current datagrams
    input dsp_pkg::dsp_dgram_t cur_dgram,
    input wire logic cur_valid,
    output logic cur_ready,
    // Motion requests
    input wire logic step_req,
    input wire logic dir_req,
    // Driver pins
    output dsp_pkg::dsp_pins_t spi_pins,
    input wire logic spi_miso,
    output logic step_output_pin,
    output logic direction_output_pin,
    // Interrupt
    output logic irq
);
    import dsp_pkg::*;

    typedef struct packed {
        logic [31:0] conf;
        logic [31:0] sdt;
        logic [31:0] cov_lo;
        logic [7:0] cov_hi;
        logic [7:0] rep_hi;
        logic [31:0] rep_lo;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic cover_pend;
        dsp_kind_t kind;
        logic [23:0] poll_cnt;
        logic aw_ok;
        logic [6:0] aw_idx;
        logic w_ok;
        logic [31:0] wdat;
        logic [3:0] wstb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [2:0] miso_s;
        logic miso_ok;
        logic [7:0] step_cnt;
        logic step_on;
        logic step_pend;
        logic [7:0] dir_wait;
        logic dir_out;
    } dsp_top_st_t;

    dsp_top_st_t s;
    dsp_top_st_t n;
    logic sh_start;
    logic sh_busy;
    logic sh_done;
    logic [DG_W-1:0] sh_tx;
    logic [DG_W-1:0] sh_rx;
    logic spi_mode;
    logic sd_mode;
    logic enabled;
    logic [23:0] poll_ival;

    // Merge a write word into a register under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] stb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (stb[i])
            begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Mode decode
    // ==========================================================
    // A nonzero cover length selects a foreign datagram size, so the datagram scheduler idles.
    assign spi_mode = (s.conf[FMT_LSB +: 4] == FMT_SPI);
    assign sd_mode = (s.conf[FMT_LSB +: 4] == FMT_SD);
    assign enabled = (s.conf[CLEN_LSB +: 7] == 7'h00) && (spi_mode || sd_mode);
    assign poll_ival = 24'(POLL_BLOCK_CYCLES) << s.conf[EXP_LSB +: 4];

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        n = s;
        sh_start = 1'b0;
        sh_tx = '0;
        cur_ready = 1'b0;
        awready = !s.aw_ok && !s.bvalid;
        wready = !s.w_ok && !s.bvalid;
        arready = !s.rvalid;
        // Three stage miso synchroniser; a level counts once stages two and three agree.
        n.miso_s = {s.miso_s[1:0], spi_miso};
        if (s.miso_s[1] == s.miso_s[2])
        begin
            n.miso_ok = s.miso_s[2];
        end
        // Read channel; a status read clears it before this cycle's events set it.
        if (s.rvalid && rready)
        begin
            n.rvalid = 1'b0;
        end
        if (arvalid && arready)
        begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = '0;
            case (araddr[ADDR_W-1:2])
                IDX_CONF: n.rdata = s.conf;
                IDX_SDT: n.rdata = s.sdt;
                IDX_COV_LO: n.rdata = s.cov_lo;
                IDX_COV_HI: n.rdata = {24'h000000, s.cov_hi};
                IDX_REP_HI: n.rdata = {24'h000000, s.rep_hi};
                IDX_REP_LO: n.rdata = s.rep_lo;
                IDX_MASK: n.rdata = {30'h00000000, s.mask};
                IDX_STAT:
                begin
                    n.rdata = {30'h00000000, s.status};
                    n.status = '0;
                end
                default: n.rresp = RESP_SLVERR;
            endcase
        end
        // Datagram scheduler: cover first, then currents, then polls.
        if (s.poll_cnt != 24'h000000)
        begin
            n.poll_cnt = s.poll_cnt - 24'h000001;
        end
        if (sh_done)
        begin
            n.kind = KIND_NONE;
            case (s.kind)
                KIND_COVER:
                begin
                    n.status[ST_COVER_DONE] = 1'b1;
                    n.rep_hi = sh_rx[DG_W-1 -: 8];
                    n.rep_lo = sh_rx[31:0];
                end
                KIND_CURRENT:
                begin
                    if (!s.conf[CDONLY_BIT])
                    begin
                        n.status[ST_COVER_DONE] = 1'b1;
                    end
                end
                KIND_POLL:
                begin
                    n.status[ST_COVER_DONE] = 1'b1;
                    n.status[ST_POLL_DONE] = 1'b1;
                end
                default: n.kind = KIND_NONE;
            endcase
        end
        else if (s.kind == KIND_NONE && enabled && !sh_busy)
        begin
            // Only one datagram is ever in flight.
            if (s.cover_pend)
            begin
                sh_start = 1'b1;
                sh_tx = {s.cov_hi, s.cov_lo};
                n.kind = KIND_COVER;
                n.cover_pend = 1'b0;
            end
            else if (spi_mode && cur_valid)
            begin
                cur_ready = 1'b1;
                sh_start = 1'b1;
                sh_tx = {cur_dgram.addr, cur_dgram.data};
                n.kind = KIND_CURRENT;
            end
            else if (sd_mode && !s.conf[DISPOLL_BIT] && s.poll_cnt == 24'h000000)
            begin
                sh_start = 1'b1;
                sh_tx = {POLL_ADDR, 32'h00000000};
                n.kind = KIND_POLL;
                n.poll_cnt = poll_ival - 24'h000001;
            end
        end
        // Write channel; placed after the scheduler so a new cover request wins.
        if (s.bvalid && bready)
        begin
            n.bvalid = 1'b0;
        end
        if (awvalid && awready)
        begin
            n.aw_ok = 1'b1;
            n.aw_idx = awaddr[ADDR_W-1:2];
        end
        if (wvalid && wready)
        begin
            n.w_ok = 1'b1;
            n.wdat = wdata;
            n.wstb = wstrb;
        end
        if (s.aw_ok && s.w_ok)
        begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (s.aw_idx)
                IDX_CONF: n.conf = merge(s.conf, s.wdat, s.wstb);
                IDX_SDT: n.sdt = merge(s.sdt, s.wdat, s.wstb);
                IDX_COV_HI: n.cov_hi = s.wstb[0] ? s.wdat[7:0] : s.cov_hi;
                IDX_MASK: n.mask = s.wstb[0] ? s.wdat[ST_W-1:0] : s.mask;
                IDX_COV_LO:
                begin
                    n.cov_lo = merge(s.cov_lo, s.wdat, s.wstb);
                    n.cover_pend = 1'b1;
                end
                IDX_REP_HI, IDX_REP_LO, IDX_STAT: n.bresp = RESP_OKAY;
                default: n.bresp = RESP_SLVERR;
            endcase
        end
        // Step and direction pins, live only in step/direction format.
        if (s.dir_wait != 8'h00)
        begin
            n.dir_wait = s.dir_wait - 8'h01;
        end
        if (s.step_on)
        begin
            if (s.step_cnt == 8'h00)
            begin
                n.step_on = 1'b0;
            end
            else
            begin
                n.step_cnt = s.step_cnt - 8'h01;
            end
        end
        if (sd_mode && step_req)
        begin
            n.step_pend = 1'b1;
            if (dir_req != s.dir_out)
            begin
                n.dir_out = dir_req;
                n.dir_wait = s.sdt[DIRSET_LSB +: 8];
            end
        end
        if (sd_mode && s.step_pend && s.dir_wait == 8'h00 && !s.step_on)
        begin
            n.step_pend = 1'b0;
            n.step_on = 1'b1;
            n.step_cnt = s.sdt[STPEXT_LSB +: 8];
        end
        if (!sd_mode)
        begin
            n.step_on = 1'b0;
            n.step_pend = 1'b0;
        end
    end

    // Register the whole state.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.conf <= CONF_RST;
            s.sdt <= SDT_RST;
            s.kind <= KIND_NONE;
        end
        else
        begin
            s <= n;
        end
    end

    // ==========================================================
    // Shift engine and outputs
    // ==========================================================
    dsp_shifter u_shifter
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(sh_start),
        .tx(sh_tx),
        .busy(sh_busy),
        .done(sh_done),
        .rx(sh_rx),
        .pins(spi_pins),
        .miso(s.miso_ok)
    );

    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign step_output_pin = s.step_on;
    assign direction_output_pin = s.dir_out;
    assign irq = |(s.status & s.mask);

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_cover_req;
        s.cover_pend && s.kind == KIND_NONE && enabled && !sh_busy && !sh_done;
    endsequence
    sequence s_cover_sent;
        s.kind == KIND_COVER ##1 !spi_pins.cs_n;
    endsequence
    property p_cover_go;
        @(posedge aclk) disable iff (!aresetn)
        s_cover_req |=> s_cover_sent;
    endproperty
    a_cover_go: assert property (p_cover_go) else $error("cover not started");

    property p_cover_done;
        @(posedge aclk) disable iff (!aresetn)
        (sh_done && s.kind == KIND_COVER) |=> s.status[ST_COVER_DONE];
    endproperty
    a_cover_done: assert property (p_cover_done) else $error("cover done missing");

    property p_reply;
        @(posedge aclk) disable iff (!aresetn)
        (sh_done && s.kind == KIND_COVER) |=> ({s.rep_hi, s.rep_lo} == $past(sh_rx));
    endproperty
    a_reply: assert property (p_reply) else $error("reply not captured");

    property p_no_current_sd;
        @(posedge aclk) disable iff (!aresetn)
        (s.kind == KIND_CURRENT) |-> !sd_mode;
    endproperty
    a_no_current_sd: assert property (p_no_current_sd) else $error("current in sd mode");

    property p_current_go;
        @(posedge aclk) disable iff (!aresetn)
        (spi_mode && enabled && cur_valid && !s.cover_pend && s.kind == KIND_NONE
         && !sh_busy && !sh_done) |-> cur_ready ##1 (s.kind == KIND_CURRENT);
    endproperty
    a_current_go: assert property (p_current_go) else $error("current not sent");

    property p_cdonly;
        @(posedge aclk) disable iff (!aresetn)
        (sh_done && s.kind == KIND_CURRENT && s.conf[CDONLY_BIT] && !s.status[ST_COVER_DONE])
        |=> !s.status[ST_COVER_DONE];
    endproperty
    a_cdonly: assert property (p_cdonly) else $error("cover done on current");

    property p_poll_gap;
        @(posedge aclk) disable iff (!aresetn)
        (sh_start && n.kind == KIND_POLL) |=> (s.poll_cnt == $past(poll_ival) - 24'h000001);
    endproperty
    a_poll_gap: assert property (p_poll_gap) else $error("poll interval wrong");

    property p_poll_done;
        @(posedge aclk) disable iff (!aresetn)
        (sh_done && s.kind == KIND_POLL) |=> (s.status == 2'h3);
    endproperty
    a_poll_done: assert property (p_poll_done) else $error("poll done missing");

    property p_step_quiet;
        @(posedge aclk) disable iff (!aresetn)
        !sd_mode |=> !step_output_pin;
    endproperty
    a_step_quiet: assert property (p_step_quiet) else $error("step outside sd mode");
endmodule

// [verilog/dsp_shifter.sv]
// Serial shift engine for one 40 bit datagram, clock idle high.
// Assumes miso is already synchronised to aclk by the caller.
`timescale 1ns/100ps
module dsp_shifter
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Request and answer
    input wire logic start,
    input wire logic [dsp_pkg::DG_W-1:0] tx,
    output logic busy,
    output logic done,
    output logic [dsp_pkg::DG_W-1:0] rx,
    // Driver pins
    output dsp_pkg::dsp_pins_t pins,
    input wire logic miso
);
    import dsp_pkg::*;

    typedef struct packed {
        logic busy;
        logic lead;
        logic sclk;
        logic cs_n;
        logic done;
        logic [7:0] cnt;
        logic [5:0] bits;
        logic [DG_W-1:0] sh;
        logic [DG_W-1:0] rx;
    } dsp_sh_st_t;

    dsp_sh_st_t s;
    dsp_sh_st_t n;

    // ==========================================================
    // Bit sequencing
    // ==========================================================
    // Data changes on the falling edge and is sampled at the end of the
    // high phase, which leaves the slow synchroniser a whole clock period.
    always_comb
    begin
        n = s;
        n.done = 1'b0;
        if (start && !s.busy)
        begin
            n.busy = 1'b1;
            n.lead = 1'b1;
            n.cs_n = 1'b0;
            n.sclk = 1'b1;
            n.cnt = HALF_CYC - 8'h01;
            n.bits = DG_BITS;
            n.sh = tx;
        end
        else if (s.busy)
        begin
            if (s.cnt != 8'h00)
            begin
                n.cnt = s.cnt - 8'h01;
            end
            else
            begin
                n.cnt = HALF_CYC - 8'h01;
                if (!s.sclk)
                begin
                    n.sclk = 1'b1;
                end
                else if (s.lead)
                begin
                    n.lead = 1'b0;
                    n.sclk = 1'b0;
                end
                else
                begin
                    n.rx = {s.rx[DG_W-2:0], miso};
                    n.sh = {s.sh[DG_W-2:0], 1'b0};
                    n.bits = s.bits - 6'h01;
                    if (s.bits == 6'h01)
                    begin
                        n.busy = 1'b0;
                        n.cs_n = 1'b1;
                        n.done = 1'b1;
                    end
                    else
                    begin
                        n.sclk = 1'b0;
                    end
                end
            end
        end
    end

    // Register the whole state.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.cs_n <= 1'b1;
            s.sclk <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

    assign busy = s.busy;
    assign done = s.done;
    assign rx = s.rx;
    assign pins = '{cs_n: s.cs_n, sclk: s.sclk, mosi: s.sh[DG_W-1]};

    // ==========================================================
    // Checks
    // ==========================================================
    // Rising clock edges seen within the current frame.
    logic [6:0] rise_cnt;
    logic sclk_d;
    always_ff @(posedge aclk)
    begin
        sclk_d <= s.sclk;
        if (!aresetn || (start && !s.busy))
        begin
            rise_cnt <= 7'h00;
        end
        else if (s.sclk && !sclk_d && !s.cs_n)
        begin
            rise_cnt <= rise_cnt + 7'h01;
        end
    end

    property p_len;
        @(posedge aclk) disable iff (!aresetn)
        s.done |-> (rise_cnt == 7'(DG_W));
    endproperty
    a_len: assert property (p_len) else $error("frame is not 40 bits");

    property p_msb_first;
        @(posedge aclk) disable iff (!aresetn)
        (start && !s.busy) |=> (pins.mosi == $past(tx[DG_W-1])) && !pins.cs_n;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit not msb");
endmodule
